//--- src/legacy_map_pkg.sv
// Purpose: shared constants and carriers for the legacy memory decoder
// Assumes: one core clock, synchronous active low reset
// Notes:   addresses are 36 bits so cycles above 4 GB can be seen
package legacy_map_pkg;

	localparam int ADDR_W = 36;
	localparam int DCA_W  = 24;

	// host memory and I/O space limits
	localparam logic [3:0]  HIGH_ADDR_ZERO = 4'h0;
	localparam logic [16:0] IO_LIMIT       = 17'h10003;

	// compatibility area boundaries (20-bit addresses)
	localparam logic [19:0] DOS_END     = 20'h9FFFF;
	localparam logic [19:0] VGA_BASE    = 20'hA0000;
	localparam logic [19:0] VGA_END     = 20'hBFFFF;
	localparam logic [19:0] PAGE_END    = 20'hAFFFF;
	localparam logic [19:0] MONO_BASE   = 20'hB0000;
	localparam logic [19:0] MONO_END    = 20'hB7FFF;
	localparam logic [19:0] SEG_BASE    = 20'hC0000;
	localparam logic [19:0] SEG_SIZE    = 20'h04000;
	localparam logic [19:0] BIOS_BASE   = 20'hF0000;
	localparam logic [19:0] BIOS_SIZE   = 20'h10000;
	localparam int          SMALL_SEGS  = 12;
	localparam int          ATTR_SEGS   = 13;

	// monochrome adapter I/O ports
	localparam logic [16:0] MONO_IO_0 = 17'h003B4;
	localparam logic [16:0] MONO_IO_1 = 17'h003B5;
	localparam logic [16:0] MONO_IO_2 = 17'h003B8;
	localparam logic [16:0] MONO_IO_3 = 17'h003B9;
	localparam logic [16:0] MONO_IO_4 = 17'h003BA;
	localparam logic [16:0] MONO_IO_5 = 17'h003BF;

	// indexed graphics register ports
	localparam logic [16:0] GFX_INDEX_PORT = 17'h003CE;
	localparam logic [16:0] GFX_DATA_PORT  = 17'h003CF;
	localparam logic [7:0]  IDX_MAP_CTRL   = 8'h10;
	localparam logic [7:0]  IDX_PAGE_SEL   = 8'h11;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;

	// address mapping control fields
	localparam int PAGE_EN_BIT     = 0;
	localparam int PAGE_TARGET_BIT = 4;
	localparam logic [7:0] MAP_CTRL_MASK = 8'h1F;

	typedef enum logic [1:0]
	{
		SRC_CPU    = 2'h0,
		SRC_HUB    = 2'h1,
		SRC_PERIPH = 2'h2
	} source_type;

	typedef enum logic [2:0]
	{
		TGT_NONE   = 3'h0,
		TGT_DRAM   = 3'h1,
		TGT_HUB    = 3'h2,
		TGT_GFX    = 3'h3,
		TGT_TERM   = 3'h4,
		TGT_ABORT  = 3'h5,
		TGT_DCACHE = 3'h6
	} target_type;

	typedef struct packed
	{
		logic              valid;
		logic              is_io;
		logic              is_write;
		logic              system_management_mode;
		source_type        src;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} host_req_type;

	typedef struct packed
	{
		logic             valid;
		target_type       target;
		logic [7:0]       rdata;
		logic [DCA_W-1:0] dc_addr;
	} route_resp_type;

endpackage

//--- src/segment_attr_decode.sv
// Purpose: one attribute-controlled segment: hit and DRAM decision
// Assumes: addr is the low 20 bits of a memory cycle below 1 MB
// Notes:   a clear enable for the cycle's own direction means the cycle goes downstream
`timescale 1ns/1ps
`default_nettype none
module segment_attr_decode
#(
	parameter logic [19:0] BASE = 20'h00000,
	parameter logic [19:0] SIZE = 20'h04000
)
(
	input  wire logic [19:0] addr_in,
	input  wire logic        is_write_in,
	input  wire logic        write_enable_in,
	input  wire logic        segment_read_enable_in,
	output logic             hit_out,
	output logic             to_dram_out
);

	// limit computed once per instance; top segment ends at 1 MB
	localparam logic [20:0] LIMIT = {1'b0, BASE} + {1'b0, SIZE};

	always_comb
	begin
		hit_out = ({1'b0, addr_in} >= {1'b0, BASE}) &&
			({1'b0, addr_in} < LIMIT);
		to_dram_out = hit_out && (is_write_in ? write_enable_in
			: segment_read_enable_in);
	end

endmodule
`default_nettype wire

//--- src/legacy_memory_region_decoder.sv
// Purpose: routes host and hub cycles in the low 1 MB and above 4 GB
// Assumes: one request per cycle, answer registered one cycle later
// Notes:   configuration bits outside the graphics index pair are pins
`timescale 1ns/1ps
`default_nettype none
module legacy_memory_region_decoder
(
	input  wire logic                         clk_in,
	input  wire logic                         rst_n_in,
	input  wire legacy_map_pkg::host_req_type req_in,
	input  wire logic [1:0]                   graphics_memory_select_bits_in,
	input  wire logic                         gfx_mem_enable_in,
	input  wire logic                         mono_adapter_forward_bit_in,
	input  wire logic                         mgmt_ram_open_in,
	input  wire logic [12:0]                  write_enable_in,
	input  wire logic [12:0]                  segment_read_enable_in,
	output legacy_map_pkg::route_resp_type    resp_out,
	output logic [7:0]                        display_cache_page_select_out,
	output logic [7:0]                        address_mapping_control_out
);
	import legacy_map_pkg::*;

	logic [7:0]     display_cache_page_select_reg;
	logic [7:0]     address_mapping_control_reg;
	logic [7:0]     gfx_index_reg;
	route_resp_type resp_reg;
	route_resp_type resp_next;

	logic [19:0]          low_addr;
	logic [16:0]          io_addr;
	logic                 above_4g;
	logic                 mem_cycle;
	logic                 io_cycle;
	logic                 in_dos;
	logic                 in_vga;
	logic                 in_page_win;
	logic                 in_mono;
	logic                 mono_port;
	logic                 below_1m;
	logic                 vga_to_gfx;
	logic                 page_en;
	logic                 page_to_dcache;
	logic                 idx_wr;
	logic                 data_wr;
	logic [ATTR_SEGS-1:0] seg_hit;
	logic [ATTR_SEGS-1:0] seg_dram;

	assign low_addr  = req_in.addr[19:0];
	assign io_addr   = req_in.addr[16:0];
	assign mem_cycle = req_in.valid && !req_in.is_io;
	assign io_cycle  = req_in.valid && req_in.is_io;

	// anything set in bits 35:32 lies beyond the 4 GB space
	assign above_4g = mem_cycle &&
		(req_in.addr[ADDR_W-1:32] != HIGH_ADDR_ZERO);
	assign below_1m = req_in.addr[ADDR_W-1:20] == '0;
	assign in_dos   = below_1m && (low_addr <= DOS_END);
	assign in_vga   = below_1m && (low_addr >= VGA_BASE) &&
		(low_addr <= VGA_END);
	assign in_page_win = in_vga && (low_addr <= PAGE_END);
	assign in_mono  = in_vga && (low_addr >= MONO_BASE) &&
		(low_addr <= MONO_END);
	assign mono_port = (io_addr == MONO_IO_0) || (io_addr == MONO_IO_1) ||
		(io_addr == MONO_IO_2) || (io_addr == MONO_IO_3) ||
		(io_addr == MONO_IO_4) || (io_addr == MONO_IO_5);

	// internal graphics owns the video buffer only when memory is carved
	assign vga_to_gfx = (graphics_memory_select_bits_in != 2'h0) &&
		gfx_mem_enable_in;
	assign page_en        = address_mapping_control_reg[PAGE_EN_BIT];
	assign page_to_dcache = address_mapping_control_reg[PAGE_TARGET_BIT];

	// graphics index pair, reached by processor I/O writes only
	assign idx_wr  = io_cycle && req_in.is_write &&
		(req_in.src == SRC_CPU) && (io_addr == GFX_INDEX_PORT);
	assign data_wr = io_cycle && req_in.is_write &&
		(req_in.src == SRC_CPU) && (io_addr == GFX_DATA_PORT);

	// thirteen attribute segments: twelve 16-KB, then the 64-KB BIOS
	genvar g;
	generate
		for (g = 0; g < ATTR_SEGS; g++)
		begin : seg
			localparam logic [19:0] B = (g < SMALL_SEGS) ?
				20'(SEG_BASE + 20'(g) * SEG_SIZE) : BIOS_BASE;
			localparam logic [19:0] S = (g < SMALL_SEGS) ?
				SEG_SIZE : BIOS_SIZE;
			segment_attr_decode
			#(
				.BASE (B),
				.SIZE (S)
			)
			u_seg
			(
				.addr_in                (low_addr),
				.is_write_in            (req_in.is_write),
				.write_enable_in        (write_enable_in[g]),
				.segment_read_enable_in (segment_read_enable_in[g]),
				.hit_out                (seg_hit[g]),
				.to_dram_out            (seg_dram[g])
			);
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			gfx_index_reg <= RESET_BYTE;
		else if (idx_wr)
			gfx_index_reg <= req_in.wdata;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			display_cache_page_select_reg <= RESET_BYTE;
		else if (data_wr && gfx_index_reg == IDX_PAGE_SEL)
			display_cache_page_select_reg <= req_in.wdata;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			address_mapping_control_reg <= RESET_BYTE;
		else if (data_wr && gfx_index_reg == IDX_MAP_CTRL)
			address_mapping_control_reg <= req_in.wdata & MAP_CTRL_MASK;
	end

	// priority chosen so fixed ranges win; overlap of programmable
	// ranges is not checked, software must keep them apart
	always_comb
	begin
		resp_next = '0;
		resp_next.valid = req_in.valid;
		resp_next.target = TGT_NONE;
		if (io_cycle)
		begin
			if (req_in.addr[ADDR_W-1:17] != '0 ||
				io_addr >= IO_LIMIT)
				resp_next.target = TGT_TERM;
			else if (mono_adapter_forward_bit_in && mono_port)
				resp_next.target = TGT_HUB;
			else if (io_addr == GFX_INDEX_PORT ||
				io_addr == GFX_DATA_PORT)
			begin
				resp_next.target = TGT_GFX;
				if (!req_in.is_write && io_addr == GFX_INDEX_PORT)
					resp_next.rdata = gfx_index_reg;
				else if (!req_in.is_write &&
					gfx_index_reg == IDX_PAGE_SEL)
					resp_next.rdata = display_cache_page_select_reg;
				else if (!req_in.is_write &&
					gfx_index_reg == IDX_MAP_CTRL)
					resp_next.rdata = address_mapping_control_reg;
			end
			else
				resp_next.target = TGT_HUB;
		end
		else if (mem_cycle)
		begin
			if (above_4g)
			begin
				// write data is simply not passed on; read data zero
				resp_next.target = TGT_TERM;
				resp_next.rdata = 8'h00;
			end
			else if (!below_1m)
				resp_next.target = TGT_HUB;
			else if (in_dos)
				resp_next.target = TGT_DRAM;
			else if (in_vga)
			begin
				// attribute bits play no part in this range
				if (req_in.src == SRC_PERIPH)
					resp_next.target = TGT_ABORT;
				else if (req_in.system_management_mode && mgmt_ram_open_in &&
					req_in.src == SRC_CPU)
					resp_next.target = TGT_DRAM;
				else if (mono_adapter_forward_bit_in && in_mono)
					resp_next.target = TGT_HUB;
				else if (page_en && in_page_win &&
					page_to_dcache && req_in.src == SRC_CPU)
				begin
					resp_next.target = TGT_DCACHE;
					resp_next.dc_addr = {display_cache_page_select_reg,
						low_addr[15:0]};
				end
				else if (vga_to_gfx)
				begin
					// hub reads are aborted; every other cycle reaching here goes to graphics
					if (req_in.src == SRC_HUB && !req_in.is_write)
						resp_next.target = TGT_ABORT;
					else
						resp_next.target = TGT_GFX;
				end
				else
					resp_next.target = TGT_HUB;
			end
			else if ((seg_hit & seg_dram) != '0)
				resp_next.target = TGT_DRAM;
			else
				// disabled memory stays hidden, no remap
				resp_next.target = TGT_HUB;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			resp_reg <= '0;
		else
			resp_reg <= resp_next;
	end

	assign resp_out                      = resp_reg;
	assign display_cache_page_select_out = display_cache_page_select_reg;
	assign address_mapping_control_out   = address_mapping_control_reg;

	// checks against the request one cycle back
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_high_addr_term: assert property (
		mem_cycle && req_in.addr[ADDR_W-1:32] != HIGH_ADDR_ZERO
		|=> resp_out.valid && resp_out.target == TGT_TERM)
		else $error("above 4 GB not terminated");

	a_high_read_zero: assert property (
		mem_cycle && !req_in.is_write && above_4g
		|=> resp_out.rdata == 8'h00 && resp_out.target != TGT_HUB)
		else $error("above 4 GB read not zero");

	a_dos_to_dram: assert property (
		mem_cycle && below_1m && low_addr <= DOS_END
		|=> resp_out.target == TGT_DRAM)
		else $error("dos area not routed to dram");

	a_periph_vga_abort: assert property (
		mem_cycle && in_vga && req_in.src == SRC_PERIPH
		|=> resp_out.target == TGT_ABORT)
		else $error("peripheral video access not aborted");

	a_hub_vga_read: assert property (
		mem_cycle && in_vga && req_in.src == SRC_HUB && !req_in.is_write
		|=> resp_out.target != TGT_GFX)
		else $error("hub read reached graphics side");

	a_mono_io_hub: assert property (
		io_cycle && mono_adapter_forward_bit_in && io_addr == MONO_IO_4
		|=> resp_out.target == TGT_HUB)
		else $error("mono port not forwarded");

	a_page_sel_write: assert property (
		data_wr && gfx_index_reg == IDX_PAGE_SEL
		|=> display_cache_page_select_out == $past(req_in.wdata))
		else $error("page selector not written");

	a_page_sel_hold: assert property (
		!(data_wr && gfx_index_reg == IDX_PAGE_SEL)
		|=> $stable(display_cache_page_select_out))
		else $error("page selector changed unasked");

	a_dcache_addr: assert property (
		resp_out.valid && resp_out.target == TGT_DCACHE
		|-> resp_out.dc_addr[DCA_W-1:16] == display_cache_page_select_out
		&& $past(address_mapping_control_out[PAGE_TARGET_BIT]))
		else $error("display cache address wrong");

	a_bios_attr: assert property (
		mem_cycle && below_1m && low_addr >= BIOS_BASE &&
		!req_in.is_write && !segment_read_enable_in[ATTR_SEGS-1]
		|=> resp_out.target == TGT_HUB)
		else $error("bios read without enable hit dram");

	// antecedents use the raw request so a wrong priority shows up
	a_io_limit_term: assert property (
		io_cycle && (req_in.addr[ADDR_W-1:17] != '0 || io_addr >= IO_LIMIT)
		|=> resp_out.target == TGT_TERM)
		else $error("io beyond limit not terminated");

	a_map_ctrl_mask: assert property (
		data_wr && gfx_index_reg == IDX_MAP_CTRL
		|=> address_mapping_control_out ==
			($past(req_in.wdata) & MAP_CTRL_MASK))
		else $error("map control write wrong");

	a_mono_mem_hub: assert property (
		mem_cycle && in_mono && mono_adapter_forward_bit_in &&
		req_in.src == SRC_HUB
		|=> resp_out.target == TGT_HUB)
		else $error("mono memory not forwarded");

	a_vga_no_dram: assert property (
		mem_cycle && in_vga && !req_in.system_management_mode
		|=> resp_out.target != TGT_DRAM)
		else $error("video buffer reached dram outside mgmt mode");

	a_mgmt_vga_dram: assert property (
		mem_cycle && in_vga && req_in.system_management_mode &&
		mgmt_ram_open_in && req_in.src == SRC_CPU
		|=> resp_out.target == TGT_DRAM)
		else $error("open mgmt ram video access not sent to dram");

	a_seg_write_off: assert property (
		mem_cycle && below_1m && low_addr >= SEG_BASE &&
		req_in.is_write && write_enable_in == '0
		|=> resp_out.target == TGT_HUB)
		else $error("segment write without enable hit dram");

	a_dcache_cpu_only: assert property (
		mem_cycle && req_in.src != SRC_CPU
		|=> resp_out.target != TGT_DCACHE)
		else $error("non processor cycle paged to display cache");

	a_hub_vga_write: assert property (
		mem_cycle && in_vga && req_in.src == SRC_HUB && req_in.is_write &&
		vga_to_gfx && !(mono_adapter_forward_bit_in && in_mono)
		|=> resp_out.target == TGT_GFX)
		else $error("hub write not steered to graphics");

endmodule
`default_nettype wire

//--- tb/host_port_model.sv
// Purpose: processor and hub side source of host cycles
// Assumes: one request at a time, held for exactly one clock
// Notes:   released address and data lines show inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
	input  wire logic                    clk_in,
	output legacy_map_pkg::host_req_type req_out
);
	import legacy_map_pkg::*;

	initial
	begin
		req_out = '0;
	end

	// drive just after an edge, hold through the sampling edge
	task automatic issue(input logic io, input logic wr, input logic sm,
		input source_type s, input logic [ADDR_W-1:0] a,
		input logic [7:0] d);
		@(posedge clk_in);
		#1;
		req_out.valid = 1'b1;
		req_out.is_io = io;
		req_out.is_write = wr;
		req_out.system_management_mode = sm;
		req_out.src = s;
		req_out.addr = a;
		req_out.wdata = d;
		@(posedge clk_in);
		#1;
		// inverted lines so a stale address cannot look like a hit
		req_out.valid = 1'b0;
		req_out.addr = ~a;
		req_out.wdata = ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the legacy memory region decoder
// Assumes: each answer shows within three cycles of its request
// Notes:   expectations follow the region map, not the design
`timescale 1ns/1ps
`default_nettype none
module tb;
	import legacy_map_pkg::*;
	logic           clk_in;
	logic           rst_n_in;
	host_req_type   req;
	route_resp_type resp;
	logic [1:0]     mem_select;
	logic           gfx_en;
	logic           mono;
	logic           mgmt_open;
	logic [12:0]    we;
	logic [12:0]    rd_en;
	logic [2:0]     pick;
	logic           rw;
	source_type     src;
	logic [7:0]     page_sel;
	logic [7:0]     map_ctrl;
	logic [7:0]     pg;
	logic [35:0]    a;
	logic [16:0]    ports [6];
	int             num_errors;
	int             checks;
	int             seed;

	host_port_model host
	(
		.clk_in  (clk_in),
		.req_out (req)
	);

	legacy_memory_region_decoder dut
	(
		.clk_in                         (clk_in),
		.rst_n_in                       (rst_n_in),
		.req_in                         (req),
		.graphics_memory_select_bits_in (mem_select),
		.gfx_mem_enable_in              (gfx_en),
		.mono_adapter_forward_bit_in    (mono),
		.mgmt_ram_open_in               (mgmt_open),
		.write_enable_in                (we),
		.segment_read_enable_in         (rd_en),
		.resp_out                       (resp),
		.display_cache_page_select_out  (page_sel),
		.address_mapping_control_out    (map_ctrl)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// bounded wait: a missing answer ends the run
	task automatic send(input logic io, input logic wr, input logic sm,
		input source_type s, input logic [ADDR_W-1:0] ad,
		input logic [7:0] d);
		int n;
		n = 0;
		host.issue(io, wr, sm, s, ad, d);
		while (resp.valid !== 1'b1 && n < 3)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check("resp valid", 1, resp.valid);
		if (resp.valid !== 1'b1)
			final_report();
	endtask

	// expected route of a non-paged memory cycle below 1 MB
	function automatic target_type exp_mem(input logic [19:0] ad,
		input logic wr, input source_type s);
		int i;
		if (ad <= DOS_END)
			return TGT_DRAM;
		if (ad <= VGA_END)
		begin
			if (s == SRC_PERIPH)
				return TGT_ABORT;
			if (mono && ad >= MONO_BASE && ad <= MONO_END)
				return TGT_HUB;
			if (mem_select == 2'h0 || !gfx_en)
				return TGT_HUB;
			return (s == SRC_HUB && !wr) ? TGT_ABORT : TGT_GFX;
		end
		i = (ad >= BIOS_BASE) ? 12 : int'((ad - SEG_BASE) >> 14);
		return (wr ? we[i] : rd_en[i]) ? TGT_DRAM : TGT_HUB;
	endfunction

	initial
	begin
		rst_n_in = 1'b0;
		mem_select = 2'h0;
		gfx_en = 1'b0;
		mono = 1'b0;
		mgmt_open = 1'b0;
		we = '0;
		rd_en = '0;
		num_errors = 0;
		checks = 0;
		seed = 34;
		ports = '{MONO_IO_0, MONO_IO_1, MONO_IO_2, MONO_IO_3, MONO_IO_4,
			MONO_IO_5};
		repeat (16) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		check("idle valid", 0, resp.valid);
		check("page select", 8'h00, page_sel);
		check("map control", 8'h00, map_ctrl);
		$display("test reset done");

		// random cycles below 1 MB under random steering and attributes
		repeat (300)
		begin
			mem_select = 2'($random(seed));
			gfx_en = 1'($random(seed));
			mono = 1'($random(seed));
			we = 13'($random(seed));
			rd_en = 13'($random(seed));
			pick = 3'($random(seed));
			rw = pick[0];
			src = pick[2] ? SRC_HUB : (pick[1] ? SRC_PERIPH : SRC_CPU);
			a = '0;
			a[19:0] = 20'($random(seed));
			send(1'b0, rw, 1'b0, src, a, 8'h00);
			check("mem target", exp_mem(a[19:0], rw, src),
				resp.target);
		end
		$display("test random map done");

		// every attribute state of every segment, edges of each segment
		for (int i = 0; i < ATTR_SEGS; i++)
			for (int st = 0; st < 4; st++)
			begin
				we = '0;
				rd_en = '0;
				we[i] = st[0];
				rd_en[i] = st[1];
				a = '0;
				a[19:0] = (i == 12) ? BIOS_BASE
					: SEG_BASE + 20'(i) * SEG_SIZE;
				if (st[0])
					a[19:0] = a[19:0] + ((i == 12) ? BIOS_SIZE : SEG_SIZE) - 20'h1;
				send(1'b0, 1'b0, 1'b0, SRC_CPU, a, 8'h00);
				check("seg read",
					st[1] ? TGT_DRAM : TGT_HUB, resp.target);
				send(1'b0, 1'b1, 1'b0, SRC_CPU, a, 8'h00);
				check("seg write",
					st[0] ? TGT_DRAM : TGT_HUB, resp.target);
			end
		$display("test segments done");

		// video buffer steered to internal graphics
		mem_select = 2'h1;
		gfx_en = 1'b1;
		mono = 1'b0;
		a = 36'h00000A0000;
		send(1'b0, 1'b0, 1'b0, SRC_PERIPH, a, 8'h00);
		check("periph abort", TGT_ABORT, resp.target);
		send(1'b0, 1'b1, 1'b0, SRC_HUB, a, 8'h00);
		check("hub write", TGT_GFX, resp.target);
		send(1'b0, 1'b0, 1'b0, SRC_HUB, a, 8'h00);
		check("hub read", TGT_ABORT, resp.target);
		send(1'b0, 1'b0, 1'b0, SRC_CPU, a, 8'h00);
		check("cpu video", TGT_GFX, resp.target);
		mgmt_open = 1'b1;
		send(1'b0, 1'b0, 1'b1, SRC_CPU, a, 8'h00);
		check("mgmt video", TGT_DRAM, resp.target);
		mgmt_open = 1'b0;
		mono = 1'b1;
		send(1'b0, 1'b0, 1'b0, SRC_CPU, 36'h00000B7FFF, 8'h00);
		check("mono mem", TGT_HUB, resp.target);
		for (int i = 0; i < 6; i++)
		begin
			send(1'b1, 1'(i), 1'b0, SRC_CPU, 36'(ports[i]), 8'h00);
			check("mono io", TGT_HUB, resp.target);
		end
		mono = 1'b0;
		$display("test video done");

		// above 4 GB and beyond the I/O limit
		repeat (8)
		begin
			a = 36'($random(seed));
			a[35:32] = 4'h1 + 4'($unsigned($random(seed)) % 15);
			send(1'b0, 1'b0, 1'b0, SRC_CPU, a, 8'h00);
			check("high read", TGT_TERM, resp.target);
			check("high rdata", 8'h00, resp.rdata);
			send(1'b0, 1'b1, 1'b0, SRC_CPU, a, 8'($random(seed)));
			check("high write", TGT_TERM, resp.target);
		end
		send(1'b1, 1'b0, 1'b0, SRC_CPU, 36'h000010003, 8'h00);
		check("io limit", TGT_TERM, resp.target);
		$display("test termination done");

		// page selector, map control and paged display cache access
		pg = 8'($random(seed));
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_INDEX_PORT), IDX_PAGE_SEL);
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), pg);
		check("page select", pg, page_sel);
		send(1'b1, 1'b0, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), 8'h00);
		check("page readback", pg, resp.rdata);
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_INDEX_PORT), IDX_MAP_CTRL);
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), 8'hFF);
		check("map reserved", 8'h1F, map_ctrl);
		send(1'b1, 1'b0, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), 8'h00);
		check("map readback", 8'h1F, resp.rdata);
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), 8'h11);
		a = 36'h00000A0000;
		a[15:0] = 16'($random(seed));
		send(1'b0, 1'b0, 1'b0, SRC_CPU, a, 8'h00);
		check("paged target", TGT_DCACHE, resp.target);
		check("paged addr", {pg, a[15:0]}, resp.dc_addr);
		send(1'b1, 1'b1, 1'b0, SRC_CPU, 36'(GFX_DATA_PORT), 8'h01);
		send(1'b0, 1'b0, 1'b0, SRC_CPU, a, 8'h00);
		check("legacy page", TGT_GFX, resp.target);
		$display("test paging done");
		final_report();
	end
endmodule
`default_nettype wire
